// ===== verilog/prog_mem_pkg.sv
package prog_mem_pkg;

    localparam int ADDR_W = 21;
    localparam logic [ADDR_W-1:0] SPACE_TOP = 21'h1FFFFF;

    // two-bit mode field codes
    typedef enum logic [1:0] {
        EXTENDED_COMBINED_MODE = 2'h0,
        BOOT_BLOCK_PLUS_EXTERNAL_MODE = 2'h1,
        EXTERNAL_ONLY_MODE = 2'h2,
        INTERNAL_ONLY_MODE = 2'h3
    } pm_mode_t;

    typedef enum logic [1:0] {
        ACC_FETCH = 2'h0,
        ACC_TABLE_READ = 2'h1,
        ACC_TABLE_WRITE = 2'h2
    } acc_kind_t;

    typedef enum logic [1:0] {
        VEC_RESET = 2'h0,
        VEC_HIGH = 2'h1,
        VEC_LOW = 2'h2
    } vec_kind_t;

    localparam logic [ADDR_W-1:0] RESET_VECTOR = 21'h000000;
    localparam logic [ADDR_W-1:0] HIGH_VECTOR = 21'h000008;
    localparam logic [ADDR_W-1:0] LOW_VECTOR = 21'h000018;

    // flash variants
    localparam logic [ADDR_W-1:0] LIMIT_32K = 21'h007FFF;
    localparam logic [ADDR_W-1:0] LIMIT_64K = 21'h00FFFF;
    localparam logic [ADDR_W-1:0] LIMIT_128K = 21'h01FFFF;
    localparam logic [ADDR_W-1:0] BOOT_32K = 21'h0007FF;
    localparam logic [ADDR_W-1:0] BOOT_LARGE = 21'h0001FF;

    localparam logic [31:0] NO_OPERATION_INSTRUCTION = 32'h0000_0000;

    // register map, byte addresses
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_MEMCTL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // config byte fields
    localparam int CFG_WAIT_BIT = 7;
    localparam int CFG_MODE_HI = 1;
    localparam int CFG_MODE_LO = 0;
    localparam logic [7:0] CFG_IMPL_MASK = 8'h83;
    localparam logic [7:0] CFG_RESET = 8'h83;

    // memory control register fields
    localparam int WAIT_COUNT_HIGH = 5;
    localparam int WAIT_COUNT_LOW = 4;
    localparam logic [7:0] MEMCTL_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verilog/decode_if.sv
`timescale 1ns/1ps
interface decode_if;
    import prog_mem_pkg::*;
    pm_mode_t mode;
    acc_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic int_hit;
    logic ext_hit;
    logic zero_fill;
    logic denied;

    modport requester (output mode, output kind, output addr,
        input int_hit, input ext_hit, input zero_fill, input denied);
    modport decoder (input mode, input kind, input addr,
        output int_hit, output ext_hit, output zero_fill, output denied);
endinterface // decode_if

// ===== verilog/region_decoder.sv
`timescale 1ns/1ps
module region_decoder
    import prog_mem_pkg::*;
#(
    parameter int FLASH_KBYTES = 32
) (
    decode_if.decoder dec
);
    localparam logic [ADDR_W-1:0] LIMIT = (FLASH_KBYTES == 128) ? LIMIT_128K :
        (FLASH_KBYTES == 64) ? LIMIT_64K : LIMIT_32K;
    // larger parts carry the smaller boot block
    localparam logic [ADDR_W-1:0] BOOT = (FLASH_KBYTES == 32) ? BOOT_32K : BOOT_LARGE;

    logic in_flash;
    logic in_boot;

    assign in_flash = dec.addr <= LIMIT;
    assign in_boot = dec.addr <= BOOT;

    always_comb begin
        dec.int_hit = 1'b0;
        dec.ext_hit = 1'b0;
        case (dec.mode)
            EXTERNAL_ONLY_MODE: begin
                dec.ext_hit = 1'b1;
            end
            BOOT_BLOCK_PLUS_EXTERNAL_MODE: begin
                dec.int_hit = in_boot;
                dec.ext_hit = !in_boot;
            end
            EXTENDED_COMBINED_MODE: begin
                dec.int_hit = in_flash;
                dec.ext_hit = !in_flash;
            end
            default: begin
                dec.int_hit = in_flash;
            end
        endcase
    end

    assign dec.zero_fill = !dec.int_hit && !dec.ext_hit && (dec.kind != ACC_TABLE_WRITE);
    assign dec.denied = !dec.int_hit && !dec.ext_hit && (dec.kind == ACC_TABLE_WRITE);

endmodule // region_decoder

// ===== verilog/program_memory_mode_decoder.sv
// Notes on behaviour
// - Program addresses are 21 bits wide and span a linear 2-Mbyte space.
// - A fetch above implemented memory and below 2 Mbytes returns an all-zero no-op word.
// - Reset starts at 0000h and the two interrupt vectors are 0008h and 0018h.
// - The mode field decodes 11 internal-only, 10 external-only, 01 boot-block, 00 extended.
// - External-only mode sends every access outside and ignores on-chip flash.
// - Boot-block mode serves up to 0007FFh (32K part) or 0001FFh (larger) from flash.
// - Internal-only mode uses flash alone and returns zeros above 7FFFh, 0FFFFh or 1FFFFh.
// - A variant with no external bus always runs internal-only.
// - Extended mode maps all flash from zero and external memory above it.
// - Table reads and writes obey the same internal and external permissions as fetches.
// - Data RAM and data EEPROM stay fully reachable in every mode.
// - Data and program memory have separate buses usable in the same cycle.
// - Wait bit 1 gives no wait states; 0 uses bits 5:4 of the memory control register.
// - Bits 6 to 2 of the config byte read as zero.
// - Erased config reads wait and mode bits as 1, so internal-only with no waits.
// - Flash is 32, 64 or 128 Kbytes depending on the variant.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module program_memory_mode_decoder
    import prog_mem_pkg::*;
#(
    parameter int FLASH_KBYTES = 32,
    parameter bit HAS_EXT_BUS = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic prog_req,
    input wire acc_kind_t prog_kind,
    input wire logic [ADDR_W-1:0] prog_addr,
    output logic prog_done_q,
    output logic int_sel_q,
    output logic ext_sel_q,
    output logic zero_fill_q,
    output logic denied_q,
    output logic [ADDR_W-1:0] bus_addr_q,
    output logic [1:0] wait_states_q,
    input wire logic vec_req,
    input wire vec_kind_t vec_kind,
    output logic [ADDR_W-1:0] vector_addr_q,
    input wire logic data_req,
    output logic data_ack_q
);
    logic [7:0] cfg_q;
    logic [1:0] wait_cnt_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    pm_mode_t mode_d;
    logic [1:0] wait_d;
    logic do_write;
    logic [31:0] rd_word;
    logic rd_ok;
    logic cfg_wr;
    logic memctl_wr;
    logic known_aw;

    decode_if dec ();

    region_decoder #(.FLASH_KBYTES(FLASH_KBYTES)) u_region (
        .dec(dec)
    );

    always_comb begin
        if (!HAS_EXT_BUS) begin
            mode_d = INTERNAL_ONLY_MODE;
        end else begin
            case ({cfg_q[CFG_MODE_HI], cfg_q[CFG_MODE_LO]})
                INTERNAL_ONLY_MODE: begin
                    mode_d = INTERNAL_ONLY_MODE;
                end
                EXTERNAL_ONLY_MODE: begin
                    mode_d = EXTERNAL_ONLY_MODE;
                end
                BOOT_BLOCK_PLUS_EXTERNAL_MODE: begin
                    mode_d = BOOT_BLOCK_PLUS_EXTERNAL_MODE;
                end
                default: begin
                    mode_d = EXTENDED_COMBINED_MODE;
                end
            endcase
        end
    end

    always_comb begin
        if (cfg_q[CFG_WAIT_BIT]) begin
            // bit set: bus never stretched
            wait_d = 2'h0;
        end else begin
            wait_d = wait_cnt_q;
        end
    end

    assign dec.mode = mode_d;
    assign dec.kind = prog_kind;
    assign dec.addr = prog_addr;

    // program side decode, one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_done_q <= 1'b0;
            int_sel_q <= 1'b0;
            ext_sel_q <= 1'b0;
            zero_fill_q <= 1'b0;
            denied_q <= 1'b0;
            bus_addr_q <= RESET_VECTOR;
            wait_states_q <= 2'h0;
        end else begin
            prog_done_q <= prog_req;
            int_sel_q <= prog_req && dec.int_hit;
            ext_sel_q <= prog_req && dec.ext_hit;
            zero_fill_q <= prog_req && dec.zero_fill;
            denied_q <= prog_req && dec.denied;
            // bus address and waits hold between requests
            if (prog_req) begin
                bus_addr_q <= prog_addr;
                wait_states_q <= dec.ext_hit ? wait_d : 2'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            vector_addr_q <= RESET_VECTOR;
        end else if (vec_req) begin
            case (vec_kind)
                VEC_HIGH: begin
                    vector_addr_q <= HIGH_VECTOR;
                end
                VEC_LOW: begin
                    vector_addr_q <= LOW_VECTOR;
                end
                default: begin
                    vector_addr_q <= RESET_VECTOR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_ack_q <= 1'b0;
        end else begin
            data_ack_q <= data_req;
        end
    end

    // axi write: address and data taken in either order
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    // register selects from the held write address
    assign cfg_wr = do_write && w_strb_q[0] && aw_addr_q[7:2] == OFS_CONFIG[7:2];
    assign memctl_wr = do_write && w_strb_q[0] && aw_addr_q[7:2] == OFS_MEMCTL[7:2];
    // status is read only but mapped, so a write to it still answers okay
    assign known_aw = aw_addr_q[7:2] == OFS_CONFIG[7:2] || aw_addr_q[7:2] == OFS_MEMCTL[7:2]
        || aw_addr_q[7:2] == OFS_STATUS[7:2];

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
        end else if (bvalid_q && s_axi_bready) begin
            aw_held_q <= 1'b0;
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (bvalid_q && s_axi_bready) begin
            w_held_q <= 1'b0;
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= known_aw ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // config byte: writable to model programming, takes effect at once
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= w_data_q[7:0] & CFG_IMPL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wait_cnt_q <= MEMCTL_RESET[WAIT_COUNT_HIGH:WAIT_COUNT_LOW];
        end else if (memctl_wr) begin
            wait_cnt_q <= w_data_q[WAIT_COUNT_HIGH:WAIT_COUNT_LOW];
        end
    end

    // read mux; status is read only
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr[7:2])
            OFS_CONFIG[7:2]: begin
                rd_word = {24'h000000, cfg_q};
            end
            OFS_MEMCTL[7:2]: begin
                rd_word = {26'h0000000, wait_cnt_q, 4'h0};
            end
            OFS_STATUS[7:2]: begin
                rd_word = {20'h00000, ext_sel_q, int_sel_q, zero_fill_q, denied_q,
                    2'h0, wait_d, 2'h0, mode_d};
            end
            // unmapped: zero data with an error response
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            // data captured with the address, held until rready
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // program_memory_mode_decoder

// ===== test/prog_mem_properties.sv
`timescale 1ns/1ps
module prog_mem_properties
    import prog_mem_pkg::*;
#(
    parameter int FLASH_KBYTES = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic prog_req,
    input wire acc_kind_t prog_kind,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic prog_done_q,
    input wire logic int_sel_q,
    input wire logic ext_sel_q,
    input wire logic zero_fill_q,
    input wire logic denied_q,
    input wire logic [ADDR_W-1:0] bus_addr_q,
    input wire logic [1:0] wait_states_q,
    input wire logic vec_req,
    input wire vec_kind_t vec_kind,
    input wire logic [ADDR_W-1:0] vector_addr_q,
    input wire logic data_req,
    input wire logic data_ack_q,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    // last flash word of this variant
    localparam logic [ADDR_W-1:0] LIM = (FLASH_KBYTES == 32) ? LIMIT_32K :
        ((FLASH_KBYTES == 64) ? LIMIT_64K : LIMIT_128K);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_DONE_ONE_ROUTE: assert property (prog_req |=> prog_done_q ##0
        $onehot({int_sel_q, ext_sel_q, zero_fill_q, denied_q}))
        else $error("access not answered with one route");
    AST_IDLE_QUIET: assert property (!prog_req |=>
        !(prog_done_q || int_sel_q || ext_sel_q || zero_fill_q || denied_q))
        else $error("route pulse without request");
    AST_ADDR_CAPTURE: assert property (prog_req |=> bus_addr_q == $past(prog_addr))
        else $error("bus address not the requested one");
    AST_NO_FLASH_ABOVE: assert property (prog_req && prog_addr > LIM |=> !int_sel_q)
        else $error("flash selected above its limit");
    AST_LOW_NO_HOLE: assert property (prog_req && prog_addr <= BOOT_LARGE |=>
        !zero_fill_q && !denied_q)
        else $error("hole reported in boot area");
    AST_WRITE_NO_FILL: assert property (prog_req && prog_kind == ACC_TABLE_WRITE |=>
        !zero_fill_q)
        else $error("table write answered with zero fill");
    AST_READ_NOT_DENIED: assert property (prog_req && prog_kind != ACC_TABLE_WRITE |=>
        !denied_q)
        else $error("read access denied");
    AST_WAIT_ONLY_EXT: assert property (prog_done_q && wait_states_q != 2'h0 |-> ext_sel_q)
        else $error("wait states on internal access");
    AST_VEC_RESET: assert property (vec_req && vec_kind == VEC_RESET |=>
        vector_addr_q == 21'h000000)
        else $error("reset vector wrong");
    AST_VEC_IRQ: assert property (vec_req && vec_kind != VEC_RESET |=> vector_addr_q ==
        (($past(vec_kind) == VEC_HIGH) ? 21'h000008 : 21'h000018))
        else $error("interrupt vector wrong");
    AST_DATA_ACK: assert property (1'b1 |=> data_ack_q == $past(data_req))
        else $error("data access not acknowledged");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    AST_WRITE_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");

    COV_EXT: cover property (ext_sel_q);
    COV_FILL: cover property (zero_fill_q);
    COV_DENIED: cover property (denied_q);
    COV_WAIT: cover property (prog_done_q && wait_states_q == 2'h3);
endmodule // prog_mem_properties

bind program_memory_mode_decoder prog_mem_properties #(.FLASH_KBYTES(FLASH_KBYTES))
    u_prog_mem_properties (.clk, .rst, .prog_req, .prog_kind, .prog_addr, .prog_done_q,
    .int_sel_q, .ext_sel_q, .zero_fill_q, .denied_q, .bus_addr_q, .wait_states_q, .vec_req,
    .vec_kind, .vector_addr_q, .data_req, .data_ack_q, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);

// ===== test/ext_prog_mem.sv
`timescale 1ns/1ps
module ext_prog_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic sel,
    input wire logic [20:0] addr,
    output logic [15:0] hits_q,
    output logic [20:0] last_q
);
    always_ff @(posedge clk) begin
        if (rst) begin
            last_q <= 21'h000000;
        end else if (sel) begin
            last_q <= addr;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            hits_q <= 16'h0000;
        end else if (sel) begin
            hits_q <= hits_q + 16'h0001;
        end
    end
endmodule // ext_prog_mem

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import prog_mem_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, wait_states_q;
    logic prog_req, prog_done_q, int_sel_q, ext_sel_q, zero_fill_q, denied_q;
    logic vec_req, data_req, data_ack_q;
    acc_kind_t prog_kind;
    vec_kind_t vec_kind;
    logic [ADDR_W-1:0] prog_addr, bus_addr_q, vector_addr_q, ext_last;
    logic [15:0] hits_q;
    int error_cnt = 0;
    int compares = 0;
    int n_ext = 0;
    logic [ADDR_W-1:0] addrs [6] = '{21'h0, 21'h7FF, 21'h800, 21'h7FFF, 21'h8000, 21'h1FFFFF};
    logic [ADDR_W-1:0] vecs [3] = '{21'h000000, 21'h000008, 21'h000018};

    always #20 clk = ~clk;

    program_memory_mode_decoder u_program_memory_mode_decoder (.clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_req,
        .prog_kind, .prog_addr, .prog_done_q, .int_sel_q, .ext_sel_q, .zero_fill_q, .denied_q,
        .bus_addr_q, .wait_states_q, .vec_req, .vec_kind, .vector_addr_q, .data_req,
        .data_ack_q);
    ext_prog_mem u_ext_prog_mem (.clk(clk), .rst(rst), .sel(ext_sel_q), .addr(bus_addr_q),
        .hits_q(hits_q), .last_q(ext_last));

    task end_of_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task chk(input bit ok, input string m);
        compares++;
        if (!ok) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit dn;
        dn = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !dn; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                dn = 1'b1;
                s_axi_bready <= 1'b0;
                chk(s_axi_bresp === er, "write response");
            end
        end
        chk(dn, "write timeout");
        if (!dn) end_of_test;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        bit dn;
        dn = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !dn; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                dn = 1'b1;
                d = s_axi_rdata;
                s_axi_rready <= 1'b0;
                chk(s_axi_rresp === er, "read response");
            end
        end
        chk(dn, "read timeout");
        if (!dn) end_of_test;
    endtask

    // expected route {int, ext, fill, denied}
    function automatic logic [3:0] route(input int m, input acc_kind_t k,
        input logic [ADDR_W-1:0] a);
        case (m)
            3: route = (a <= LIMIT_32K) ? 4'h8 : ((k == ACC_TABLE_WRITE) ? 4'h1 : 4'h2);
            2: route = 4'h4;
            1: route = (a <= BOOT_32K) ? 4'h8 : 4'h4;
            default: route = (a <= LIMIT_32K) ? 4'h8 : 4'h4;
        endcase
    endfunction

    task acc(input acc_kind_t k, input logic [ADDR_W-1:0] a, input logic [3:0] e,
        input logic wb);
        @(posedge clk);
        prog_req <= 1'b1;
        prog_kind <= k;
        prog_addr <= a;
        @(posedge clk);
        prog_req <= 1'b0;
        #1;
        chk({prog_done_q, int_sel_q, ext_sel_q, zero_fill_q, denied_q} === {1'b1, e}, "route");
        chk(bus_addr_q === a, "bus address");
        chk(wait_states_q === ((e[2] && !wb) ? 2'h3 : 2'h0), "wait count");
        chk(data_ack_q === data_req, "data side");
        if (e[2]) n_ext++;
    endtask

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {prog_req, vec_req, data_req, prog_addr} = '0;
        prog_kind = ACC_FETCH;
        vec_kind = VEC_RESET;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CONFIG, rd_v, RESP_OKAY);
        chk(rd_v === 32'h83, "erased config");
        rd(8'h0C, rd_v, RESP_SLVERR);
        chk(rd_v === 32'h0, "unmapped read");
        wr(8'h0C, 32'hFF, RESP_SLVERR);
        wr(OFS_CONFIG, 32'h0, RESP_OKAY);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CONFIG, rd_v, RESP_OKAY);
        chk(rd_v === 32'h83, "config after reset");
        acc(ACC_FETCH, 21'h8000, 4'h2, 1'b1);
        wr(OFS_MEMCTL, 32'hFF, RESP_OKAY);
        rd(OFS_MEMCTL, rd_v, RESP_OKAY);
        chk(rd_v === 32'h30, "memory control");
        data_req <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            // odd modes run with the wait bit set
            wr(OFS_CONFIG, {24'h0, m[0], 5'h1F, m[1:0]}, RESP_OKAY);
            rd(OFS_CONFIG, rd_v, RESP_OKAY);
            chk(rd_v === {24'h0, m[0], 5'h0, m[1:0]}, "config readback");
            rd(OFS_STATUS, rd_v, RESP_OKAY);
            chk(rd_v[1:0] === m[1:0], "effective mode");
            for (int i = 0; i < 6; i++) begin
                for (int k = 0; k < 3; k++) begin
                    acc(acc_kind_t'(k), addrs[i], route(m, acc_kind_t'(k), addrs[i]), m[0]);
                end
            end
        end
        data_req <= 1'b0;
        // reset vector last, so a stale zero cannot pass
        for (int k = 2; k >= 0; k--) begin
            @(posedge clk);
            vec_req <= 1'b1;
            vec_kind <= vec_kind_t'(k);
            @(posedge clk);
            vec_req <= 1'b0;
            #1;
            chk(vector_addr_q === vecs[k], "vector");
        end
        chk(hits_q === n_ext[15:0], "external access count");
        chk(ext_last === SPACE_TOP, "last external address");
        end_of_test;
    end
endmodule // tb_top
